//--- dis_pkg.sv
// Constants and types for the door interlock and spindle clamp block
package dis_pkg;
   localparam int NUM_AXES = 8;
   localparam int NUM_SPINDLES = 2;
   localparam int SPEED_W = 16;
   localparam int DIST_W = 32;
   localparam int CLK_MHZ = 100;
   localparam int MISMATCH_TIME_S = 3;
   localparam longint MISMATCH_CYCLES_L = longint'(MISMATCH_TIME_S) * longint'(CLK_MHZ) * 64'd1000000;
   localparam int MISMATCH_CYCLES = int'(MISMATCH_CYCLES_L);
   localparam int MISMATCH_CNT_W = 32;
   localparam int OPTION_W = 8;
   localparam int OPT_CLAMP_VALID_BIT = 5;
   localparam logic [7:0] SERVO_ALARM_DOOR_CODE = 8'h5d;
   localparam logic [7:0] ALARM_NONE = 8'h00;
   typedef enum logic [3:0] {
      DIS_RUN = 4'b0001,
      DIS_DECEL = 4'b0010,
      DIS_POWER_OFF = 4'b0100,
      DIS_OPEN = 4'b1000
   } dis_door_state_type;
endpackage

//--- dis_door_interlock.sv
// Door interlock sequencer, spindle door monitor and door clamp speed selector
`timescale 1ns/1ps
module dis_door_interlock #(
   parameter int MISMATCH_LIMIT = dis_pkg::MISMATCH_CYCLES
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic door_open_request,
   input wire logic [dis_pkg::NUM_AXES-1:0] axis_stopped,
   input wire logic [dis_pkg::NUM_SPINDLES-1:0] spindle_stopped,
   input wire logic [dis_pkg::NUM_AXES-1:0] program_axis_moving,
   input wire logic [dis_pkg::DIST_W-1:0] program_axis_remaining [dis_pkg::NUM_AXES],
   input wire logic [dis_pkg::NUM_SPINDLES-1:0] door_state_bit,
   input wire logic [dis_pkg::NUM_SPINDLES-1:0] door_closed_wired,
   input wire logic door_clamp_request,
   input wire logic [dis_pkg::OPTION_W-1:0] door_clamp_option_word,
   input wire logic orientation_active,
   input wire logic tap_zero_return_active,
   input wire logic c_axis_zero_return_active,
   input wire logic [dis_pkg::SPEED_W-1:0] orientation_clamp_speed,
   input wire logic [dis_pkg::SPEED_W-1:0] tap_zero_return_clamp_speed,
   input wire logic [dis_pkg::SPEED_W-1:0] c_axis_zero_return_clamp_speed,
   input wire logic [dis_pkg::SPEED_W-1:0] door_interlock_clamp_speed,
   output logic axis_interlock,
   output logic decel_stop,
   output logic contactor_on,
   output logic servo_ready_complete,
   output logic servo_on,
   output logic door_open_enable,
   output logic [dis_pkg::NUM_AXES-1:0] dynamic_brake,
   output logic [dis_pkg::DIST_W-1:0] retained_distance [dis_pkg::NUM_AXES],
   output logic [dis_pkg::NUM_SPINDLES-1:0] door_alarm,
   output logic [7:0] spindle_alarm_code [dis_pkg::NUM_SPINDLES],
   output logic [dis_pkg::SPEED_W-1:0] spindle_clamp_speed,
   output logic clamp_alternate_active
);
   logic rst_meta;
   logic rst_sync;
   logic req_meta;
   logic req_sync;
   logic [dis_pkg::NUM_AXES-1:0] axst_meta;
   logic [dis_pkg::NUM_AXES-1:0] axst_sync;
   logic [dis_pkg::NUM_SPINDLES-1:0] spst_meta;
   logic [dis_pkg::NUM_SPINDLES-1:0] spst_sync;
   logic [dis_pkg::NUM_SPINDLES-1:0] dcw_meta;
   logic [dis_pkg::NUM_SPINDLES-1:0] dcw_sync;

   // Reset release and pin synchronisers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync) begin
      if (!rst_sync) begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
         axst_meta <= '0;
         axst_sync <= '0;
         spst_meta <= '0;
         spst_sync <= '0;
         // Idle level is door closed, so no false mismatch counts after reset
         dcw_meta <= '1;
         dcw_sync <= '1;
      end else begin
         req_meta <= door_open_request;
         req_sync <= req_meta;
         axst_meta <= axis_stopped;
         axst_sync <= axst_meta;
         spst_meta <= spindle_stopped;
         spst_sync <= spst_meta;
         dcw_meta <= door_closed_wired;
         dcw_sync <= dcw_meta;
      end
   end

   // Door sequencer
   dis_pkg::dis_door_state_type state;
   dis_pkg::dis_door_state_type next_state;
   logic next_axis_interlock;
   logic next_decel_stop;
   logic next_contactor_on;
   logic next_servo_on;
   logic next_door_open_enable;
   logic req_prev;
   logic req_rise;
   logic all_stopped;

   assign all_stopped = (&axst_sync) && (&spst_sync);

   always_comb begin
      next_state = state;
      case (state)
         dis_pkg::DIS_RUN: begin
            if (req_sync) begin
               next_state = dis_pkg::DIS_DECEL;
            end
         end
         dis_pkg::DIS_DECEL: begin
            if (!req_sync) begin
               next_state = dis_pkg::DIS_RUN;
            end else if (all_stopped) begin
               next_state = dis_pkg::DIS_POWER_OFF;
            end
         end
         dis_pkg::DIS_POWER_OFF: begin
            if (!req_sync) begin
               next_state = dis_pkg::DIS_RUN;
            end else begin
               next_state = dis_pkg::DIS_OPEN;
            end
         end
         dis_pkg::DIS_OPEN: begin
            if (!req_sync) begin
               next_state = dis_pkg::DIS_RUN;
            end
         end
         default: begin
            next_state = dis_pkg::DIS_RUN;
         end
      endcase
      next_axis_interlock = (next_state != dis_pkg::DIS_RUN);
      next_decel_stop = (next_state == dis_pkg::DIS_DECEL);
      next_contactor_on = (next_state == dis_pkg::DIS_RUN) || (next_state == dis_pkg::DIS_DECEL);
      next_servo_on = next_contactor_on;
      next_door_open_enable = (next_state == dis_pkg::DIS_OPEN);
   end

   always_ff @(posedge clk_sys or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= dis_pkg::DIS_RUN;
         axis_interlock <= 1'b0;
         decel_stop <= 1'b0;
         contactor_on <= 1'b1;
         servo_on <= 1'b1;
         servo_ready_complete <= 1'b0;
         door_open_enable <= 1'b0;
         req_prev <= 1'b0;
      end else begin
         state <= next_state;
         axis_interlock <= next_axis_interlock;
         decel_stop <= next_decel_stop;
         contactor_on <= next_contactor_on;
         servo_on <= next_servo_on;
         servo_ready_complete <= 1'b1;
         door_open_enable <= next_door_open_enable;
         req_prev <= req_sync;
      end
   end

   assign req_rise = req_sync && !req_prev;

   // Program-driven axes still moving at the request: brake and keep distance
   logic [dis_pkg::NUM_AXES-1:0] next_dynamic_brake;
   logic [dis_pkg::DIST_W-1:0] next_retained [dis_pkg::NUM_AXES];
   generate
      for (genvar a = 0; a < dis_pkg::NUM_AXES; a++) begin : g_axis
         always_comb begin
            next_dynamic_brake[a] = dynamic_brake[a];
            next_retained[a] = retained_distance[a];
            if (!req_sync) begin
               next_dynamic_brake[a] = 1'b0;
            end else if (req_rise && program_axis_moving[a]) begin
               next_dynamic_brake[a] = 1'b1;
               next_retained[a] = program_axis_remaining[a];
            end
         end
         always_ff @(posedge clk_sys or negedge rst_sync) begin
            if (!rst_sync) begin
               dynamic_brake[a] <= 1'b0;
               retained_distance[a] <= '0;
            end else begin
               dynamic_brake[a] <= next_dynamic_brake[a];
               retained_distance[a] <= next_retained[a];
            end
         end
      end
   endgenerate

   // Door state mismatch monitor per spindle
   logic [dis_pkg::MISMATCH_CNT_W-1:0] mis_cnt [dis_pkg::NUM_SPINDLES];
   logic [dis_pkg::MISMATCH_CNT_W-1:0] next_mis_cnt [dis_pkg::NUM_SPINDLES];
   logic [dis_pkg::NUM_SPINDLES-1:0] next_door_alarm;
   generate
      for (genvar s = 0; s < dis_pkg::NUM_SPINDLES; s++) begin : g_spindle
         always_comb begin
            next_mis_cnt[s] = '0;
            next_door_alarm[s] = door_alarm[s];
            // Open bit and wired closed bit at the same level disagree
            if (door_state_bit[s] == dcw_sync[s]) begin
               if (mis_cnt[s] < MISMATCH_LIMIT[dis_pkg::MISMATCH_CNT_W-1:0]) begin
                  next_mis_cnt[s] = mis_cnt[s] + 1'b1;
               end else begin
                  next_mis_cnt[s] = mis_cnt[s];
               end
               if (next_mis_cnt[s] >= MISMATCH_LIMIT[dis_pkg::MISMATCH_CNT_W-1:0]) begin
                  next_door_alarm[s] = 1'b1;
               end
            end
         end
         always_ff @(posedge clk_sys or negedge rst_sync) begin
            if (!rst_sync) begin
               mis_cnt[s] <= '0;
               door_alarm[s] <= 1'b0;
               spindle_alarm_code[s] <= dis_pkg::ALARM_NONE;
            end else begin
               mis_cnt[s] <= next_mis_cnt[s];
               door_alarm[s] <= next_door_alarm[s];
               spindle_alarm_code[s] <= next_door_alarm[s] ? dis_pkg::SERVO_ALARM_DOOR_CODE : dis_pkg::ALARM_NONE;
            end
         end
      end
   endgenerate

   // Clamp speed selection
   logic op_active;
   logic op_prev;
   logic clamp_latched;
   logic next_clamp_latched;
   logic clamp_eff;
   logic [dis_pkg::SPEED_W-1:0] next_clamp_speed;

   assign op_active = orientation_active || tap_zero_return_active || c_axis_zero_return_active;
   assign clamp_eff = door_clamp_request && door_clamp_option_word[dis_pkg::OPT_CLAMP_VALID_BIT];

   always_comb begin
      next_clamp_latched = clamp_latched;
      if (!op_active) begin
         next_clamp_latched = clamp_eff;
      end else if (!op_prev) begin
         next_clamp_latched = clamp_eff;
      end
      if (next_clamp_latched) begin
         next_clamp_speed = door_interlock_clamp_speed;
      end else if (orientation_active) begin
         next_clamp_speed = orientation_clamp_speed;
      end else if (tap_zero_return_active) begin
         next_clamp_speed = tap_zero_return_clamp_speed;
      end else begin
         next_clamp_speed = c_axis_zero_return_clamp_speed;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync) begin
      if (!rst_sync) begin
         op_prev <= 1'b0;
         clamp_latched <= 1'b0;
         clamp_alternate_active <= 1'b0;
         spindle_clamp_speed <= '0;
      end else begin
         op_prev <= op_active;
         clamp_latched <= next_clamp_latched;
         clamp_alternate_active <= next_clamp_latched;
         spindle_clamp_speed <= next_clamp_speed;
      end
   end

   sequence s_stopped_req;
      req_sync && state == dis_pkg::DIS_DECEL && all_stopped;
   endsequence
   sequence s_power_then_enable;
      !contactor_on ##1 door_open_enable;
   endsequence

   a_decel_on_rise: assert property (@(posedge clk_sys) disable iff (!rst_sync)
      $rose(req_sync) && state == dis_pkg::DIS_RUN |=> decel_stop && axis_interlock)
      else $error("no deceleration after door request");
   a_power_cut_order: assert property (@(posedge clk_sys) disable iff (!rst_sync)
      s_stopped_req ##1 req_sync |-> s_power_then_enable)
      else $error("power cut or enable sequence wrong");
   a_ready_kept: assert property (@(posedge clk_sys) disable iff (!rst_sync)
      !contactor_on |-> servo_ready_complete)
      else $error("servo ready dropped with power off");
   a_enable_needs_off: assert property (@(posedge clk_sys) disable iff (!rst_sync)
      door_open_enable |-> !contactor_on && !servo_on)
      else $error("enable without power removed");
   a_release_restore: assert property (@(posedge clk_sys) disable iff (!rst_sync)
      $fell(req_sync) |=> servo_on && contactor_on && !door_open_enable)
      else $error("release did not restore ready");
   a_brake_keep: assert property (@(posedge clk_sys) disable iff (!rst_sync)
      req_rise && program_axis_moving[1] |=> dynamic_brake[1]
      && retained_distance[1] == $past(program_axis_remaining[1]))
      else $error("program axis not braked");
   a_alarm_match: assert property (@(posedge clk_sys) disable iff (!rst_sync)
      door_state_bit[0] != dcw_sync[0] && !door_alarm[0] |=> !door_alarm[0])
      else $error("alarm without mismatch");
   a_clamp_option: assert property (@(posedge clk_sys) disable iff (!rst_sync)
      !door_clamp_option_word[dis_pkg::OPT_CLAMP_VALID_BIT] && !op_active |=> !clamp_alternate_active)
      else $error("clamp taken with option off");
   a_clamp_hold: assert property (@(posedge clk_sys) disable iff (!rst_sync)
      op_active && op_prev ##1 op_active |-> clamp_latched == $past(clamp_latched))
      else $error("clamp changed during operation");
   a_clamp_speed: assert property (@(posedge clk_sys) disable iff (!rst_sync)
      clamp_latched |-> spindle_clamp_speed == $past(door_interlock_clamp_speed))
      else $error("alternate clamp speed not applied");
endmodule

//--- dis_seq_program.sv
// Sequence program model that requests door opening and reports door state
`timescale 1ns/1ps
module dis_seq_program (
   input wire logic clk_sys,
   input wire logic open_cmd,
   input wire logic rude,
   input wire logic [dis_pkg::NUM_AXES-1:0] move_mask,
   input wire logic [dis_pkg::NUM_SPINDLES-1:0] wrong_mask,
   input wire logic [dis_pkg::NUM_SPINDLES-1:0] spindle_stopped,
   input wire logic door_open_enable,
   output logic door_open_request,
   output logic [dis_pkg::NUM_AXES-1:0] program_axis_moving,
   output logic [dis_pkg::NUM_SPINDLES-1:0] door_state_bit
);
   initial begin
      door_open_request = 1'b0;
      program_axis_moving = '0;
   end
   // A rude program raises the request with its own axes still moving
   always @(posedge clk_sys) begin
      if (!open_cmd) begin
         door_open_request <= 1'b0;
         program_axis_moving <= move_mask;
      end else if (program_axis_moving != '0 && !rude) begin
         program_axis_moving <= '0;
      end else begin
         door_open_request <= 1'b1;
      end
   end
   // Door counts as open once enabled, still commanded and spindles seen stopped
   assign door_state_bit = {2{door_open_enable & open_cmd & (&spindle_stopped)}} ^ wrong_mask;
endmodule

//--- test_dis_door_interlock.sv
// Testbench for the door interlock block
`timescale 1ns/1ps
module test_dis_door_interlock;
   logic clk_sys, resetn, open_cmd, rude, door_clamp_request;
   logic door_open_request, orientation_active, tap_zero_return_active, c_axis_zero_return_active;
   logic axis_interlock, decel_stop, contactor_on, servo_ready_complete, servo_on, door_open_enable;
   logic clamp_alternate_active;
   logic [7:0] move_mask, axis_stopped, program_axis_moving, dynamic_brake, door_clamp_option_word;
   logic [1:0] wrong_mask, spindle_stopped, door_state_bit, door_closed_wired, door_alarm;
   logic [31:0] rem [8];
   logic [31:0] retained_distance [8];
   logic [7:0] spindle_alarm_code [2];
   logic [15:0] spindle_clamp_speed;
   logic [15:0] spd [3];
   int num_errors, n_checks;

   dis_seq_program i_dis_seq_program (.clk_sys(clk_sys), .open_cmd(open_cmd), .rude(rude),
      .move_mask(move_mask), .wrong_mask(wrong_mask), .spindle_stopped(spindle_stopped),
      .door_open_enable(door_open_enable),
      .door_open_request(door_open_request), .program_axis_moving(program_axis_moving),
      .door_state_bit(door_state_bit));
   dis_door_interlock #(.MISMATCH_LIMIT(20)) i_dis_door_interlock (.clk_sys(clk_sys), .resetn(resetn),
      .door_open_request(door_open_request), .axis_stopped(axis_stopped), .spindle_stopped(spindle_stopped),
      .program_axis_moving(program_axis_moving), .program_axis_remaining(rem),
      .door_state_bit(door_state_bit), .door_closed_wired(door_closed_wired),
      .door_clamp_request(door_clamp_request), .door_clamp_option_word(door_clamp_option_word),
      .orientation_active(orientation_active), .tap_zero_return_active(tap_zero_return_active),
      .c_axis_zero_return_active(c_axis_zero_return_active), .orientation_clamp_speed(spd[0]),
      .tap_zero_return_clamp_speed(spd[1]), .c_axis_zero_return_clamp_speed(spd[2]),
      .door_interlock_clamp_speed(16'h0800), .axis_interlock(axis_interlock), .decel_stop(decel_stop),
      .contactor_on(contactor_on), .servo_ready_complete(servo_ready_complete), .servo_on(servo_on),
      .door_open_enable(door_open_enable), .dynamic_brake(dynamic_brake),
      .retained_distance(retained_distance), .door_alarm(door_alarm),
      .spindle_alarm_code(spindle_alarm_code), .spindle_clamp_speed(spindle_clamp_speed),
      .clamp_alternate_active(clamp_alternate_active));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return decel_stop;
         1: return door_open_enable;
         2: return contactor_on;
         default: return door_alarm[0];
      endcase
   endfunction

   // Bounded wait on a design output reaching a level
   task automatic wait_on(input int sel, input logic lvl);
      for (int i = 0; i < 40; i++) begin
         step(1);
         if (pick(sel) === lvl) return;
      end
      num_errors++;
      $display("[ERR] %0t wait %0d timed out", $time, sel);
      summarize();
   endtask

   task automatic t_door;
      open_cmd = 1'b1;
      wait_on(0, 1'b1);
      check(axis_interlock, 1, "interlock");
      check(contactor_on, 1, "power before stop");
      step(5);
      check(door_open_enable, 0, "enable before stop");
      axis_stopped = 8'hff;
      spindle_stopped = 2'b11;
      wait_on(1, 1'b1);
      check({contactor_on, servo_on, decel_stop}, 0, "power cut");
      check(servo_ready_complete, 1, "ready kept");
      check(dynamic_brake, 0, "no brake");
      open_cmd = 1'b0;
      wait_on(2, 1'b1);
      check({servo_on, door_open_enable, axis_interlock}, 3'b100, "release");
      $display("door sequence done");
   endtask

   task automatic t_brake;
      step(3);
      rude = 1'b1;
      open_cmd = 1'b1;
      wait_on(1, 1'b1);
      check(dynamic_brake, 8'h06, "brake mask");
      check(retained_distance[1], 32'h0000_1234, "remaining 1");
      check(retained_distance[2], 32'h0000_abcd, "remaining 2");
      open_cmd = 1'b0;
      rude = 1'b0;
      wait_on(2, 1'b1);
      step(1);
      check(dynamic_brake, 0, "brake cleared");
      $display("brake test done");
   endtask

   task automatic t_alarm;
      wrong_mask = 2'b01;
      step(15);
      wrong_mask = 2'b00;
      step(5);
      wrong_mask = 2'b01;
      step(19);
      check(door_alarm, 0, "short mismatch");
      step(1);
      check(door_alarm, 2'b01, "alarm at limit");
      wait_on(3, 1'b1);
      wrong_mask = 2'b00;
      step(5);
      check(door_alarm, 2'b01, "alarm sticky");
      check({spindle_alarm_code[0], spindle_alarm_code[1]}, 16'h5d00, "alarm code");
      $display("alarm test done");
   endtask

   task automatic t_reset;
      resetn = 1'b0;
      step(1);
      check({contactor_on, servo_on, door_open_enable, axis_interlock}, 4'b1100, "reset levels");
      check(servo_ready_complete, 0, "ready in reset");
      check(door_alarm, 0, "alarm cleared");
      check(spindle_alarm_code[0], 8'h00, "code cleared");
      resetn = 1'b1;
      step(2);
      check(servo_ready_complete, 0, "ready during release");
      step(1);
      check(servo_ready_complete, 1, "ready after release");
      step(2);
      $display("reset test done");
   endtask

   task automatic set_op(input int k);
      {orientation_active, tap_zero_return_active, c_axis_zero_return_active} = (k < 0) ? 3'b000 : 3'b100 >> k;
      step(3);
   endtask

   task automatic t_clamp;
      door_clamp_request = 1'b1;
      set_op(0);
      check({clamp_alternate_active, spindle_clamp_speed}, 17'h00400, "option off");
      set_op(-1);
      door_clamp_option_word = 8'h20;
      set_op(0);
      check({clamp_alternate_active, spindle_clamp_speed}, 17'h10800, "clamp on");
      door_clamp_request = 1'b0;
      step(3);
      check(spindle_clamp_speed, 16'h0800, "held in op");
      for (int k = 0; k < 3; k++) begin
         set_op(-1);
         door_clamp_request = 1'b0;
         set_op(k);
         check(spindle_clamp_speed, spd[k], "normal clamp");
         set_op(-1);
         door_clamp_request = 1'b1;
         set_op(k);
         check(spindle_clamp_speed, 16'h0800, "alternate clamp");
      end
      set_op(-1);
      $display("clamp test done");
   endtask

   initial begin
      num_errors = 0;
      n_checks = 0;
      resetn = 1'b0;
      {open_cmd, rude, door_clamp_request} = 3'b000;
      {orientation_active, tap_zero_return_active, c_axis_zero_return_active} = 3'b000;
      move_mask = 8'h06;
      axis_stopped = 8'h00;
      spindle_stopped = 2'b00;
      wrong_mask = 2'b00;
      door_closed_wired = 2'b11;
      door_clamp_option_word = 8'h00;
      spd = '{16'h0400, 16'h0300, 16'h0200};
      foreach (rem[i]) rem[i] = 32'h0;
      rem[1] = 32'h0000_1234;
      rem[2] = 32'h0000_abcd;
      step(8);
      resetn = 1'b1;
      step(4);
      t_door();
      t_brake();
      t_alarm();
      t_reset();
      t_clamp();
      summarize();
   end
endmodule
